/* i2c_port_pkg.sv */
/*
  Shared constants for the serial register port: target address, timing
  counts for both bus speeds, register space layout and FIFO shape.
  Assumes one 200 MHz clock on both ends and a pulled-up two-wire bus.
*/
package i2c_port_pkg;
  // ****************************************
  // Addressing
  // ****************************************
  localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h2b;
  localparam logic [7:0] NVM_TARGET_ADDR_LOC = 8'h04;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] STATUS_LAST_ADDR = 8'h08;
  localparam int STATUS_BYTES = 9;
  localparam int REG_SPACE = 256;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int STD_RATE_KBPS = 100;
  localparam int FAST_RATE_KBPS = 400;
  localparam int STD_BIT_NS = 1000000 / STD_RATE_KBPS;
  localparam int FAST_BIT_NS = 1000000 / FAST_RATE_KBPS;
  localparam logic [10:0] STD_QUARTER_CYC = 11'((STD_BIT_NS / 4) / CLK_PERIOD_NS);
  localparam logic [10:0] FAST_QUARTER_CYC = 11'((FAST_BIT_NS / 4) / CLK_PERIOD_NS);

  // ****************************************
  // Write buffer
  // ****************************************
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
endpackage

/* i2c_port_if.sv */
/*
  Two-wire bus between the master end and the register port end.
  Assumes open-drain pins with pull-ups, resolved here from the enables.
*/
`timescale 1ns/1ps
interface i2c_port_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // ****************************************
  // Wired-AND with pull-up
  // ****************************************
  assign scl = (hostSclOe && !hostSclOut) ? 1'b0 : 1'b1;
  assign sda = ((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut)) ? 1'b0 : 1'b1;

  modport host (output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe,
                input scl, input sda);
  modport device (output devSdaOut, output devSdaOe, input scl, input sda);
endinterface

/* i2c_register_port.sv */
/*
  Slave end: address match, pointer handling, read and write of the
  register space, plus the write buffer that holds bytes until the next
  processing phase. Assumes bus pins sampled on the 200 MHz clock.
*/
`timescale 1ns/1ps
module write_fifo
  import i2c_port_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic [AW:0] nxt_wrPtr;
  logic [AW:0] nxt_rdPtr;
  logic doPush;
  logic doPop;

  // ****************************************
  // Pointers and flags
  // ****************************************
  always_comb begin
    outValid = (wrPtr_ff != rdPtr_ff);
    inReady = (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]) || (wrPtr_ff[AW] == rdPtr_ff[AW]);
    doPush = inValid && inReady;
    doPop = outValid && outReady;
    nxt_wrPtr = doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
    outData = mem[rdPtr_ff[AW-1:0]];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
    end
  end

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end
endmodule

module i2c_register_port
  import i2c_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  i2c_port_if.device bus,
  output logic [7:0] nvmLocation,
  input wire logic nvmAddrValid,
  input wire logic [6:0] nvmTargetAddr,
  input wire logic [8*STATUS_BYTES-1:0] statusBytes,
  input wire logic applyPhase,
  output logic applyValid,
  output logic [7:0] applyAddr,
  output logic [7:0] applyData,
  output logic [6:0] ownAddr
);
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} dstate_e;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} kind_e;

  dstate_e state_ff;
  dstate_e nxt_state;
  kind_e kind_ff;
  kind_e nxt_kind;
  logic readMode_ff;
  logic nxt_readMode;
  logic [3:0] bitCnt_ff;
  logic [3:0] nxt_bitCnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic sdaOe_ff;
  logic nxt_sdaOe;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic [6:0] ownAddr_ff;
  logic [6:0] nxt_ownAddr;
  logic applyValid_ff;
  logic [7:0] applyAddr_ff;
  logic [7:0] applyData_ff;
  logic [7:0] regFile [REG_SPACE];
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] readByte;
  logic pushValid;
  logic pushReady;
  logic popValid;
  logic [FIFO_WIDTH-1:0] popData;

  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = sdaOe_ff;
  assign nvmLocation = NVM_TARGET_ADDR_LOC;
  assign ownAddr = ownAddr_ff;
  assign applyValid = applyValid_ff;
  assign applyAddr = applyAddr_ff;
  assign applyData = applyData_ff;

  // ****************************************
  // Write buffer, drained at processing phase
  // ****************************************
  write_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData({ptr_ff, shift_ff}),
    .outValid(popValid),
    .outReady(applyPhase),
    .outData(popData)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      applyValid_ff <= 1'b0;
      applyAddr_ff <= 8'h00;
      applyData_ff <= 8'h00;
    end else begin
      applyValid_ff <= popValid && applyPhase;
      applyAddr_ff <= popData[15:8];
      applyData_ff <= popData[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (popValid && applyPhase) begin
      regFile[popData[15:8]] <= popData[7:0];
    end
  end

  // ****************************************
  // Bus event detection and read mux
  // ****************************************
  always_comb begin
    sclRise = bus.scl && !sclPrev_ff;
    sclFall = !bus.scl && sclPrev_ff;
    startSeen = bus.scl && sclPrev_ff && sdaPrev_ff && !bus.sda;
    stopSeen = bus.scl && sclPrev_ff && !sdaPrev_ff && bus.sda;
    if (ptr_ff <= STATUS_LAST_ADDR) begin
      readByte = statusBytes[8*ptr_ff[3:0] +: 8];
    end else begin
      readByte = regFile[ptr_ff];
    end
  end

  // ****************************************
  // Protocol engine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_readMode = readMode_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_ownAddr = nvmAddrValid ? nvmTargetAddr : ownAddr_ff;
    pushValid = 1'b0;
    if (stopSeen) begin
      nxt_state = D_IDLE;
      nxt_sdaOe = 1'b0;
    end else if (startSeen) begin
      nxt_state = D_RX;
      nxt_kind = K_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOe = 1'b0;
    end else begin
      unique case (state_ff)
        D_IDLE: begin
          nxt_sdaOe = 1'b0;
        end
        D_RX: begin
          if (sclRise) begin
            nxt_shift = {shift_ff[6:0], bus.sda};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (sclFall && bitCnt_ff == 4'h8) begin
            nxt_bitCnt = 4'h0;
            unique case (kind_ff)
              K_ADDR: begin
                if (shift_ff[7:1] == ownAddr_ff) begin
                  nxt_sdaOe = 1'b1;
                  nxt_readMode = (shift_ff[0] == RW_READ);
                  nxt_kind = K_PTR;
                  nxt_state = D_ACK;
                end else begin
                  nxt_state = D_IDLE;
                end
              end
              K_PTR: begin
                nxt_ptr = shift_ff;
                nxt_kind = K_DATA;
                nxt_sdaOe = 1'b1;
                nxt_state = D_ACK;
              end
              K_DATA: begin
                if (pushReady) begin
                  pushValid = (ptr_ff > STATUS_LAST_ADDR);
                  nxt_ptr = ptr_ff + 8'h01;
                  nxt_sdaOe = 1'b1;
                  nxt_state = D_ACK;
                end else begin
                  nxt_state = D_IDLE;
                end
              end
              default: begin
                nxt_state = D_IDLE;
              end
            endcase
          end
        end
        D_ACK: begin
          if (sclFall) begin
            nxt_bitCnt = 4'h0;
            if (readMode_ff) begin
              nxt_shift = readByte;
              nxt_sdaOe = !readByte[7];
              nxt_state = D_TX;
            end else begin
              nxt_sdaOe = 1'b0;
              nxt_state = D_RX;
            end
          end
        end
        D_TX: begin
          if (sclFall) begin
            nxt_bitCnt = bitCnt_ff + 4'h1;
            if (bitCnt_ff == 4'h7) begin
              nxt_sdaOe = 1'b0;
              nxt_bitCnt = 4'h0;
              nxt_state = D_MACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sdaOe = !shift_ff[6];
            end
          end
        end
        D_MACK: begin
          if (sclRise) begin
            if (!bus.sda) begin
              nxt_ptr = ptr_ff + 8'h01;
              nxt_bitCnt = 4'h1;
            end else begin
              nxt_state = D_IDLE;
            end
          end else if (sclFall && bitCnt_ff == 4'h1) begin
            nxt_bitCnt = 4'h0;
            nxt_shift = readByte;
            nxt_sdaOe = !readByte[7];
            nxt_state = D_TX;
          end
        end
        default: begin
          nxt_state = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= D_IDLE;
      kind_ff <= K_ADDR;
      readMode_ff <= 1'b0;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      sdaOe_ff <= 1'b0;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      ownAddr_ff <= DEFAULT_TARGET_ADDR;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      readMode_ff <= nxt_readMode;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      sdaOe_ff <= nxt_sdaOe;
      sclPrev_ff <= bus.scl;
      sdaPrev_ff <= bus.sda;
      ownAddr_ff <= nxt_ownAddr;
    end
  end
endmodule

/* i2c_bus_master.sv */
/*
  Master end: runs one register write or read transfer per command,
  making the bus clock from the system clock at either bus speed.
  Assumes the user holds command fields stable while cmdValid is high.
*/
`timescale 1ns/1ps
module i2c_bus_master
  import i2c_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  i2c_port_if.host bus,
  input wire logic fastMode,
  input wire logic [6:0] targetAddr,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [7:0] cmdPtr,
  input wire logic [7:0] cmdLen,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic cmdDone,
  output logic cmdNack
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_LOAD, H_STOP} hstate_e;
  typedef enum logic [2:0] {B_AW, B_PTR, B_WD, B_AR, B_RD} role_e;

  hstate_e state_ff, nxt_state;
  role_e role_ff, nxt_role;
  logic [1:0] q_ff, nxt_q;
  logic [10:0] qCnt_ff, nxt_qCnt;
  logic [3:0] bitIdx_ff, nxt_bitIdx;
  logic [8:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic ack_ff, nxt_ack;
  logic [7:0] remain_ff, nxt_remain;
  logic isRead_ff, nxt_isRead;
  logic fast_ff, nxt_fast;
  logic [6:0] addr_ff, nxt_addr;
  logic [7:0] ptr_ff, nxt_ptr;
  logic sclOe_ff, nxt_sclOe;
  logic sdaOe_ff, nxt_sdaOe;
  logic rdValid_ff, nxt_rdValid;
  logic [7:0] rdData_ff, nxt_rdData;
  logic done_ff, nxt_done;
  logic nack_ff, nxt_nack;
  logic tick;

  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSclOe = sclOe_ff;
  assign bus.hostSdaOe = sdaOe_ff;
  assign cmdReady = (state_ff == H_IDLE);
  assign wrReady = (state_ff == H_LOAD);
  assign rdValid = rdValid_ff;
  assign rdData = rdData_ff;
  assign cmdDone = done_ff;
  assign cmdNack = nack_ff;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_role = role_ff;
    nxt_q = q_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_ack = ack_ff;
    nxt_remain = remain_ff;
    nxt_isRead = isRead_ff;
    nxt_fast = fast_ff;
    nxt_addr = addr_ff;
    nxt_ptr = ptr_ff;
    nxt_rdValid = 1'b0;
    nxt_rdData = rdData_ff;
    nxt_done = 1'b0;
    nxt_nack = nack_ff;
    tick = (qCnt_ff == (fast_ff ? FAST_QUARTER_CYC : STD_QUARTER_CYC) - 11'd1);
    nxt_qCnt = (tick || state_ff == H_IDLE || state_ff == H_LOAD) ? 11'd0 : qCnt_ff + 11'd1;
    if (tick) begin
      nxt_q = q_ff + 2'd1;
    end
    // Pin levels follow the quarter of the bit in progress
    nxt_sclOe = 1'b0;
    nxt_sdaOe = sdaOe_ff;
    unique case (state_ff)
      H_IDLE: begin
        nxt_sdaOe = 1'b0;
        nxt_q = 2'd0;
        if (cmdValid) begin
          nxt_state = H_START;
          nxt_role = B_AW;
          nxt_isRead = cmdRead;
          nxt_fast = fastMode;
          nxt_addr = targetAddr;
          nxt_ptr = cmdPtr;
          nxt_remain = cmdLen;
          nxt_nack = 1'b0;
        end
      end
      H_START: begin
        nxt_sclOe = (q_ff == 2'd0 || q_ff == 2'd3);
        nxt_sdaOe = (q_ff >= 2'd2);
        if (tick && q_ff == 2'd3) begin
          nxt_state = H_BIT;
          nxt_bitIdx = 4'h0;
          nxt_tx = (role_ff == B_AW) ? {addr_ff, RW_WRITE, 1'b1} : {addr_ff, RW_READ, 1'b1};
        end
      end
      H_LOAD: begin
        nxt_sclOe = 1'b1;
        nxt_q = 2'd0;
        if (wrValid) begin
          nxt_tx = {wrData, 1'b1};
          nxt_role = B_WD;
          nxt_bitIdx = 4'h0;
          nxt_state = H_BIT;
        end
      end
      H_BIT: begin
        nxt_sclOe = (q_ff == 2'd0 || q_ff == 2'd3);
        nxt_sdaOe = !tx_ff[8];
        if (tick && q_ff == 2'd2) begin
          if (bitIdx_ff == 4'h8) begin
            nxt_ack = !bus.sda;
          end else begin
            nxt_rx = {rx_ff[6:0], bus.sda};
          end
        end
        if (tick && q_ff == 2'd3) begin
          nxt_bitIdx = bitIdx_ff + 4'h1;
          nxt_tx = {tx_ff[7:0], 1'b1};
          if (bitIdx_ff == 4'h8) begin
            nxt_bitIdx = 4'h0;
            if (!ack_ff && role_ff != B_RD) begin
              nxt_nack = 1'b1;
              nxt_state = H_STOP;
            end else begin
              unique case (role_ff)
                B_AW: begin
                  nxt_role = B_PTR;
                  nxt_tx = {ptr_ff, 1'b1};
                end
                B_PTR: begin
                  if (isRead_ff) begin
                    nxt_role = B_AR;
                    nxt_state = H_START;
                  end else if (remain_ff == 8'h00) begin
                    nxt_state = H_STOP;
                  end else begin
                    nxt_state = H_LOAD;
                  end
                end
                B_WD: begin
                  nxt_remain = remain_ff - 8'h01;
                  nxt_state = (remain_ff <= 8'h01) ? H_STOP : H_LOAD;
                end
                B_AR: begin
                  nxt_role = B_RD;
                  nxt_tx = {8'hff, (remain_ff <= 8'h01)};
                end
                B_RD: begin
                  nxt_rdValid = 1'b1;
                  nxt_rdData = rx_ff;
                  nxt_remain = remain_ff - 8'h01;
                  nxt_tx = {8'hff, (remain_ff <= 8'h02)};
                  if (remain_ff <= 8'h01) begin
                    nxt_state = H_STOP;
                  end
                end
                default: begin
                  nxt_state = H_STOP;
                end
              endcase
            end
          end
        end
      end
      H_STOP: begin
        nxt_sclOe = (q_ff == 2'd0);
        nxt_sdaOe = (q_ff <= 2'd1);
        if (tick && q_ff == 2'd3) begin
          nxt_state = H_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: begin
        nxt_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= H_IDLE;
      role_ff <= B_AW;
      q_ff <= 2'd0;
      qCnt_ff <= 11'd0;
      bitIdx_ff <= 4'h0;
      tx_ff <= 9'h1ff;
      rx_ff <= 8'h00;
      ack_ff <= 1'b0;
      remain_ff <= 8'h00;
      isRead_ff <= 1'b0;
      fast_ff <= 1'b0;
      addr_ff <= 7'h00;
      ptr_ff <= 8'h00;
      sclOe_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      rdValid_ff <= 1'b0;
      rdData_ff <= 8'h00;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      role_ff <= nxt_role;
      q_ff <= nxt_q;
      qCnt_ff <= nxt_qCnt;
      bitIdx_ff <= nxt_bitIdx;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      ack_ff <= nxt_ack;
      remain_ff <= nxt_remain;
      isRead_ff <= nxt_isRead;
      fast_ff <= nxt_fast;
      addr_ff <= nxt_addr;
      ptr_ff <= nxt_ptr;
      sclOe_ff <= nxt_sclOe;
      sdaOe_ff <= nxt_sdaOe;
      rdValid_ff <= nxt_rdValid;
      rdData_ff <= nxt_rdData;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
    end
  end
endmodule

/* i2c_port_props.sv */
/*
  Bus checker for the two-wire link between master end and register port.
  Assumes it watches the resolved lines and all enables of one interface.
*/
`timescale 1ns/1ps
module i2c_port_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  logic [10:0] lowCnt_ff;
  logic [10:0] nxt_lowCnt;
  logic frame_ff;
  logic nxt_frame;
  logic prevScl_ff;
  logic prevSda_ff;

  // ****************************************
  // Frame tracking and low-phase count
  // ****************************************
  always_comb begin
    nxt_lowCnt = scl ? 11'h000 : ((lowCnt_ff == 11'h7ff) ? lowCnt_ff : lowCnt_ff + 11'h001);
    nxt_frame = frame_ff;
    if (prevScl_ff && scl && prevSda_ff && !sda) nxt_frame = 1'b1;
    if (prevScl_ff && scl && !prevSda_ff && sda) nxt_frame = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowCnt_ff <= 11'h000;
      frame_ff <= 1'b0;
      prevScl_ff <= 1'b1;
      prevSda_ff <= 1'b1;
    end else begin
      lowCnt_ff <= nxt_lowCnt;
      frame_ff <= nxt_frame;
      prevScl_ff <= scl;
      prevSda_ff <= sda;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_oe_rise;
    $rose(devSdaOe);
  endsequence

  chk_open_drain: assert property (!hostSclOut && !hostSdaOut && !devSdaOut)
    else $error("driven high level on open-drain line");
  chk_scl_low_min: assert property ($rose(scl) |-> lowCnt_ff >= 11'h07c)
    else $error("clock low phase too short");
  chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("device data changed while clock high");
  chk_oe_rise_low: assert property (s_oe_rise |-> (!scl)[*8])
    else $error("device drive began near clock high");
  chk_oe_fall_low: assert property ($fell(devSdaOe) |-> !scl)
    else $error("device released while clock high");
  chk_start_free: assert property (s_start |-> !devSdaOe)
    else $error("device pulling data at start");
  chk_stop_release: assert property (s_stop |=> (!devSdaOe)[*4])
    else $error("device drove after stop");
  chk_idle_release: assert property (!frame_ff |-> !devSdaOe)
    else $error("device drove outside a frame");
endmodule

/* tb.sv */
/*
  Testbench joining master end and register port through one interface.
  Assumes 200 MHz clock; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  import i2c_port_pkg::*;
  logic clk, rst_n, fastMode, cmdValid, cmdReady, cmdRead, wrValid, wrReady, rdValid, cmdDone, cmdNack;
  logic nvmAddrValid, applyPhase, applyValid, oeSeen;
  logic [6:0] targetAddr, nvmTargetAddr, ownAddr;
  logic [7:0] cmdPtr, cmdLen, wrData, rdData, nvmLocation, applyAddr, applyData;
  logic [8*STATUS_BYTES-1:0] statusBytes;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [15:0] apQ[$];
  int n_fail, num_checks, nLen, nFast;

  i2c_port_if u_i2c_port_if ();
  i2c_bus_master u_i2c_bus_master (.clk(clk), .rst_n(rst_n), .bus(u_i2c_port_if.host),
    .fastMode(fastMode), .targetAddr(targetAddr), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdRead(cmdRead), .cmdPtr(cmdPtr), .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .cmdDone(cmdDone), .cmdNack(cmdNack));
  i2c_register_port u_i2c_register_port (.clk(clk), .rst_n(rst_n), .bus(u_i2c_port_if.device),
    .nvmLocation(nvmLocation), .nvmAddrValid(nvmAddrValid), .nvmTargetAddr(nvmTargetAddr),
    .statusBytes(statusBytes), .applyPhase(applyPhase), .applyValid(applyValid),
    .applyAddr(applyAddr), .applyData(applyData), .ownAddr(ownAddr));
  i2c_port_props u_i2c_port_props (.clk(clk), .rst_n(rst_n), .hostSclOut(u_i2c_port_if.hostSclOut),
    .hostSclOe(u_i2c_port_if.hostSclOe), .hostSdaOut(u_i2c_port_if.hostSdaOut),
    .hostSdaOe(u_i2c_port_if.hostSdaOe), .devSdaOut(u_i2c_port_if.devSdaOut),
    .devSdaOe(u_i2c_port_if.devSdaOe), .scl(u_i2c_port_if.scl), .sda(u_i2c_port_if.sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (applyValid === 1'b1) apQ.push_back({applyAddr, applyData});
  end

  task automatic conclude;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // One command, entered at a falling edge
  // ****************************************
  task automatic xfer(input logic rd, input logic [6:0] ta, input logic [7:0] ptr, input logic [7:0] len,
                      input logic fm);
    int i;
    int n;
    i = 0;
    n = 0;
    oeSeen = 1'b0;
    rq.delete();
    cmdValid = 1'b1;
    cmdRead = rd;
    targetAddr = ta;
    cmdPtr = ptr;
    cmdLen = len;
    fastMode = fm;
    @(negedge clk);
    cmdValid = 1'b0;
    while (n < 40000) begin
      wrValid = (i < wq.size());
      wrData = (i < wq.size()) ? wq[i] : 8'h00;
      #2;
      if (wrValid && wrReady === 1'b1) i++;
      @(negedge clk);
      if (u_i2c_port_if.devSdaOe === 1'b1) oeSeen = 1'b1;
      if (rdValid === 1'b1) rq.push_back(rdData);
      if (cmdDone === 1'b1) break;
      n++;
    end
    wrValid = 1'b0;
    nLen = n;
    `CHK("cmdDone", 1'b1, cmdDone)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    `CHK("ownAddr", 7'h2b, ownAddr)
    `CHK("nvmLocation", 8'h04, nvmLocation)
    `CHK("cmdReady", 1'b1, cmdReady)
  endtask

  task automatic t_fill;
    wq = '{8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    xfer(1'b0, 7'h2b, 8'h09, 8'h05, 1'b1);
    `CHK("fullNack", 1'b1, cmdNack)
    `CHK("earlyApply", 1'b1, apQ.size() == 0)
    applyPhase = 1'b1;
    repeat (8) @(negedge clk);
    applyPhase = 1'b0;
    `CHK("applyCount", 1'b1, apQ.size() == 4)
    for (int k = 0; k < 4; k++) `CHK("apply", {8'h09 + 8'(k), wq[k]}, apQ[k])
  endtask

  task automatic t_read;
    wq.delete();
    xfer(1'b1, 7'h2b, 8'h08, 8'h02, 1'b1);
    `CHK("readCount", 1'b1, rq.size() == 2)
    `CHK("readStatus", 8'hc8, rq[0])
    `CHK("readNext", 8'h22, rq[1])
    `CHK("readNack", 1'b0, cmdNack)
    `CHK("readDriven", 1'b1, oeSeen)
    `CHK("readRelease", 1'b0, u_i2c_port_if.devSdaOe)
  endtask

  task automatic t_foreign;
    xfer(1'b0, 7'h2a, 8'h00, 8'h00, 1'b1);
    nFast = nLen;
    `CHK("foreignNack", 1'b1, cmdNack)
    `CHK("foreignOe", 1'b0, oeSeen)
  endtask

  task automatic t_nvm;
    nvmTargetAddr = 7'h55;
    nvmAddrValid = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("storedAddr", 7'h55, ownAddr)
    wq = '{8'h77};
    xfer(1'b0, 7'h55, 8'h08, 8'h01, 1'b1);
    wq.delete();
    `CHK("storedAck", 1'b0, cmdNack)
    applyPhase = 1'b1;
    repeat (4) @(negedge clk);
    applyPhase = 1'b0;
    `CHK("statusWrite", 1'b1, apQ.size() == 4)
  endtask

  task automatic t_std;
    xfer(1'b0, 7'h2b, 8'h00, 8'h00, 1'b0);
    `CHK("oldAddrNack", 1'b1, cmdNack)
    `CHK("stdRate", 1'b1, nLen > 3 * nFast)
  endtask

  initial begin
    rst_n = 1'b0;
    fastMode = 1'b1;
    targetAddr = 7'h2b;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdPtr = 8'h00;
    cmdLen = 8'h00;
    wrValid = 1'b0;
    wrData = 8'h00;
    nvmAddrValid = 1'b0;
    nvmTargetAddr = 7'h00;
    applyPhase = 1'b0;
    n_fail = 0;
    num_checks = 0;
    nLen = 0;
    nFast = 0;
    for (int k = 0; k < STATUS_BYTES; k++) statusBytes[8*k +: 8] = 8'hc0 + 8'(k);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_fill();
    t_read();
    t_foreign();
    t_nvm();
    t_std();
    conclude();
  end

  initial begin
    repeat (120000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule
